// >>> rtl/wake_recovery_defs.svh
`ifndef WAKE_RECOVERY_DEFS_SVH
`define WAKE_RECOVERY_DEFS_SVH
// ----------------------------------------------------------------
// Register addresses (7-bit command address)
// ----------------------------------------------------------------
`define ADDR_OSC_TRIM        7'h38
`define ADDR_WAKE_OPTIONS    7'h39
`define ADDR_OSC_CAL_HIGH    7'h3a
`define ADDR_OSC_CAL_LOW     7'h3b
`define ADDR_REC_CTRL_ONE    7'h3c
`define ADDR_REC_CTRL_TWO    7'h3d
`define ADDR_REC_UPPER_LIM   7'h3e
`define ADDR_REC_LOWER_LIM   7'h3f
// ----------------------------------------------------------------
// Reset and preset values
// ----------------------------------------------------------------
`define TRIM_PRESET_BIT      1'h0
`define TRIM_VALUE_RST       7'h40
`define OPT_PRESET_BITS      5'h00
`define WAKE_RX_SEL_RST      1'h0
`define OSC_CAL_RST          8'h00
`define FILT_SEL_RST         2'h1
`define REC_EN_RST           1'h0
`define REC_CLK_SEL_RST      2'h0
`define UPPER_LIM_RST        8'ha8
`define LOWER_LIM_RST        8'h98
`define BIT_TIME_RST         8'ha0
`define TRIM_UNLOCK_KEY      2'h3
// ----------------------------------------------------------------
// Serial frame layout
// ----------------------------------------------------------------
`define FRAME_BITS           5'h10
`define FRAME_DATA_START     5'h08
`define FRAME_LAST_ADDR_BIT  5'h07
`define FRAME_RW_BIT         7
// ----------------------------------------------------------------
// Filter shifts and recovery divider masks
// ----------------------------------------------------------------
`define FILT_SHIFT_8         4'h3
`define FILT_SHIFT_16        4'h4
`define FILT_SHIFT_32        4'h5
`define ADAPT_THRESHOLD      10'h008
`define DIV_MASK_80          3'h0
`define DIV_MASK_40          3'h1
`define DIV_MASK_20          3'h3
`define DIV_MASK_10          3'h7
`endif

// >>> rtl/wake_recovery_pkg.sv
package wake_recovery_pkg;
  // Serial frame tracking state.
  typedef enum logic [0:0] {
    FRAME_IDLE   = 1'b0,
    FRAME_ACTIVE = 1'b1
  } frame_state_t;

  // Recovery filter time constant selection.
  typedef enum logic [1:0] {
    FILT_TC_8     = 2'b00,
    FILT_TC_16    = 2'b01,
    FILT_TC_32    = 2'b10,
    FILT_TC_ADAPT = 2'b11
  } filter_sel_t;

  // Recovery clock selection.
  typedef enum logic [1:0] {
    REC_CLK_80 = 2'b00,
    REC_CLK_40 = 2'b01,
    REC_CLK_20 = 2'b10,
    REC_CLK_10 = 2'b11
  } rec_clk_sel_t;
endpackage

// >>> rtl/wake_frame_recovery_config.sv
`timescale 1ns/1ns
`include "wake_recovery_defs.svh"
`default_nettype none

module wake_frame_recovery_config (
  input  wire logic                          clk_sys,
  input  wire logic                          reset_n,
  input  wire logic                          soft_reset,
  input  wire logic                          spi_csn,
  input  wire logic                          spi_sclk,
  input  wire logic                          spi_mosi,
  output logic                               spi_miso_out,
  output logic                               spi_miso_oe_n,
  input  wire logic [1:0]                    trim_unlock_key,
  input  wire logic                          osc_tick,
  input  wire logic                          wake_rx_data,
  output logic [6:0]                         oscillator_trim_value,
  output logic                               wake_receiver_select,
  output wake_recovery_pkg::filter_sel_t     filter_time_constant_select,
  output logic                               recovery_enable,
  output wake_recovery_pkg::rec_clk_sel_t    recovery_clock_select,
  output logic [7:0]                         bit_time_length_value
);
  import wake_recovery_pkg::*;

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  frame_state_t  state_ff;
  frame_state_t  nxt_state;
  logic          sclk_ff;
  logic          csn_ff;
  logic [4:0]    bit_cnt_ff;
  logic [15:0]   shift_ff;
  logic [7:0]    read_ff;
  logic          miso_ff;
  logic [6:0]    trim_ff;
  logic          rx_sel_ff;
  logic [7:0]    cal_high_ff;
  logic [7:0]    cal_low_ff;
  logic [1:0]    filt_ff;
  logic          en_ff;
  logic [1:0]    clk_sel_ff;
  logic [7:0]    upper_ff;
  logic [7:0]    lower_ff;
  logic [2:0]    div_cnt_ff;
  logic [7:0]    meas_cnt_ff;
  logic          rx_ff;
  logic [7:0]    bit_time_ff;

  // ----------------------------------------------------------------
  // Serial frame decode
  // ----------------------------------------------------------------

  // Edge detection on the serial clock, only inside a frame.
  wire        sclk_rise   = spi_sclk & ~sclk_ff & ~spi_csn;
  wire        sclk_fall   = ~spi_sclk & sclk_ff & ~spi_csn;
  wire        frame_end   = spi_csn & ~csn_ff;
  wire        frame_full  = (bit_cnt_ff == `FRAME_BITS);
  wire [6:0]  cmd_addr    = shift_ff[6:0];
  wire        cmd_write   = shift_ff[`FRAME_RW_BIT];
  wire [7:0]  wdata       = shift_ff[15:8];
  wire        addr_done   = sclk_rise & (bit_cnt_ff == `FRAME_LAST_ADDR_BIT);
  wire        in_data     = (bit_cnt_ff >= `FRAME_DATA_START) & ~frame_full;
  // A write commits only for a complete 16-bit frame with the write bit set.
  wire        wr_strobe   = frame_end & frame_full & cmd_write;
  wire        key_ok      = (trim_unlock_key == `TRIM_UNLOCK_KEY);

  // Per-register write enables.
  wire wr_trim  = wr_strobe & (cmd_addr == `ADDR_OSC_TRIM) & key_ok;
  wire wr_opt   = wr_strobe & (cmd_addr == `ADDR_WAKE_OPTIONS) & key_ok;
  wire wr_ctl1  = wr_strobe & (cmd_addr == `ADDR_REC_CTRL_ONE);
  wire wr_ctl2  = wr_strobe & (cmd_addr == `ADDR_REC_CTRL_TWO);
  wire wr_upper = wr_strobe & (cmd_addr == `ADDR_REC_UPPER_LIM);
  wire wr_lower = wr_strobe & (cmd_addr == `ADDR_REC_LOWER_LIM);

  // Read values with reserved bits forced to zero and presets fixed.
  wire [7:0] rd_trim  = {`TRIM_PRESET_BIT, trim_ff};
  wire [7:0] rd_opt   = {rx_sel_ff, 2'h0, `OPT_PRESET_BITS};
  wire [7:0] rd_ctl1  = {4'h0, filt_ff, 1'h0, en_ff};
  wire [7:0] rd_ctl2  = {6'h00, clk_sel_ff};

  // Address selection of the read word; unmapped addresses read zero.
  wire [7:0] rd_mux =
    (cmd_addr == `ADDR_OSC_TRIM)      ? rd_trim     :
    (cmd_addr == `ADDR_WAKE_OPTIONS)  ? rd_opt      :
    (cmd_addr == `ADDR_OSC_CAL_HIGH)  ? cal_high_ff :
    (cmd_addr == `ADDR_OSC_CAL_LOW)   ? cal_low_ff  :
    (cmd_addr == `ADDR_REC_CTRL_ONE)  ? rd_ctl1     :
    (cmd_addr == `ADDR_REC_CTRL_TWO)  ? rd_ctl2     :
    (cmd_addr == `ADDR_REC_UPPER_LIM) ? upper_ff    :
    (cmd_addr == `ADDR_REC_LOWER_LIM) ? lower_ff    :
                                        8'h00;

  // Frame state follows the chip select.
  always_comb begin
    case (state_ff)
      FRAME_IDLE:   nxt_state = spi_csn ? FRAME_IDLE : FRAME_ACTIVE;
      FRAME_ACTIVE: nxt_state = spi_csn ? FRAME_IDLE : FRAME_ACTIVE;
      default:      nxt_state = FRAME_IDLE;
    endcase
  end

  // ----------------------------------------------------------------
  // Serial shift logic
  // ----------------------------------------------------------------

  // Pin history and frame state.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      sclk_ff  <= 1'b0;
      csn_ff   <= 1'b1;
      state_ff <= FRAME_IDLE;
    end else begin
      sclk_ff  <= spi_sclk;
      csn_ff   <= spi_csn;
      state_ff <= nxt_state;
    end
  end

  // Bit counter and shift register; bits arrive least significant first.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bit_cnt_ff <= 5'h00;
      shift_ff   <= 16'h0000;
    end else if (state_ff == FRAME_IDLE) begin
      bit_cnt_ff <= 5'h00;
    end else if (sclk_rise && !frame_full) begin
      shift_ff[bit_cnt_ff[3:0]] <= spi_mosi;
      bit_cnt_ff                <= bit_cnt_ff + 5'h01;
    end
  end

  // The addressed register is captured once the address byte is in.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      read_ff <= 8'h00;
    end else if (addr_done) begin
      read_ff <= rd_mux;
    end
  end

  // Read data leaves on falling clock edges during the data byte.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      miso_ff <= 1'b0;
    end else if (state_ff == FRAME_IDLE) begin
      miso_ff <= 1'b0;
    end else if (sclk_fall) begin
      miso_ff <= in_data ? read_ff[bit_cnt_ff[2:0]] : 1'b0;
    end
  end

  assign spi_miso_out  = miso_ff;
  assign spi_miso_oe_n = spi_csn;

  // ----------------------------------------------------------------
  // Configuration registers
  // ----------------------------------------------------------------

  // Trim and wake receiver select, gated by the unlock key.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      trim_ff   <= `TRIM_VALUE_RST;
      rx_sel_ff <= `WAKE_RX_SEL_RST;
    end else if (soft_reset) begin
      trim_ff   <= `TRIM_VALUE_RST;
      rx_sel_ff <= `WAKE_RX_SEL_RST;
    end else begin
      if (wr_trim) begin
        trim_ff <= wdata[6:0];
      end
      if (wr_opt) begin
        rx_sel_ff <= wdata[7];
      end
    end
  end

  // Recovery controls: enable, filter constant and clock choice.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      filt_ff    <= `FILT_SEL_RST;
      en_ff      <= `REC_EN_RST;
      clk_sel_ff <= `REC_CLK_SEL_RST;
    end else if (soft_reset) begin
      filt_ff    <= `FILT_SEL_RST;
      en_ff      <= `REC_EN_RST;
      clk_sel_ff <= `REC_CLK_SEL_RST;
    end else begin
      if (wr_ctl1) begin
        filt_ff <= wdata[3:2];
        en_ff   <= wdata[0];
      end
      if (wr_ctl2) begin
        clk_sel_ff <= wdata[1:0];
      end
    end
  end

  // Bit-time clamp limits.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      upper_ff <= `UPPER_LIM_RST;
      lower_ff <= `LOWER_LIM_RST;
    end else if (soft_reset) begin
      upper_ff <= `UPPER_LIM_RST;
      lower_ff <= `LOWER_LIM_RST;
    end else begin
      if (wr_upper) begin
        upper_ff <= wdata;
      end
      if (wr_lower) begin
        lower_ff <= wdata;
      end
    end
  end

  // ----------------------------------------------------------------
  // Clock and data recovery
  // ----------------------------------------------------------------

  // Divider from the fast oscillator tick to the selected recovery rate.
  wire [2:0] div_mask =
    (clk_sel_ff == REC_CLK_80) ? `DIV_MASK_80 :
    (clk_sel_ff == REC_CLK_40) ? `DIV_MASK_40 :
    (clk_sel_ff == REC_CLK_20) ? `DIV_MASK_20 :
                                 `DIV_MASK_10;
  wire       rec_tick  = osc_tick & ((div_cnt_ff & div_mask) == div_mask);
  wire       rx_edge   = en_ff & (wake_rx_data != rx_ff);
  wire       meas_sat  = (meas_cnt_ff == 8'hff);

  // Clamp the measured interval into the programmed window.
  wire [7:0] meas_clamped =
    (meas_cnt_ff > upper_ff) ? upper_ff :
    (meas_cnt_ff < lower_ff) ? lower_ff :
                               meas_cnt_ff;

  // First-order filter toward the clamped measurement.
  wire signed [9:0] diff     = $signed({2'b00, meas_clamped}) - $signed({2'b00, bit_time_ff});
  wire        [9:0] diff_abs = diff[9] ? 10'(-diff) : 10'(diff);
  wire        [3:0] filt_shift =
    (filt_ff == FILT_TC_8)  ? `FILT_SHIFT_8  :
    (filt_ff == FILT_TC_16) ? `FILT_SHIFT_16 :
    (filt_ff == FILT_TC_32) ? `FILT_SHIFT_32 :
    ((diff_abs > `ADAPT_THRESHOLD) ? `FILT_SHIFT_8 : `FILT_SHIFT_32);
  wire signed [9:0] step     = diff >>> filt_shift;
  wire        [9:0] sum      = 10'($signed({2'b00, bit_time_ff}) + step);
  wire        [7:0] nxt_bit_time = sum[7:0];

  // Divider counter and receive history.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      div_cnt_ff <= 3'h0;
      rx_ff      <= 1'b1;
    end else begin
      rx_ff <= wake_rx_data;
      if (osc_tick) begin
        div_cnt_ff <= div_cnt_ff + 3'h1;
      end
    end
  end

  // Interval counter saturates instead of wrapping.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      meas_cnt_ff <= 8'h00;
    end else if (!en_ff || rx_edge) begin
      meas_cnt_ff <= 8'h00;
    end else if (rec_tick && !meas_sat) begin
      meas_cnt_ff <= meas_cnt_ff + 8'h01;
    end
  end

  // Filtered bit time and calibration readback update on each received edge while recovery is enabled.
  always_ff @(posedge clk_sys or negedge reset_n) begin
    if (!reset_n) begin
      bit_time_ff <= `BIT_TIME_RST;
      cal_high_ff <= `OSC_CAL_RST;
      cal_low_ff  <= `OSC_CAL_RST;
    end else if (soft_reset) begin
      bit_time_ff <= `BIT_TIME_RST;
      cal_high_ff <= `OSC_CAL_RST;
      cal_low_ff  <= `OSC_CAL_RST;
    end else if (rx_edge) begin
      bit_time_ff <= nxt_bit_time;
      cal_high_ff <= meas_cnt_ff;
      cal_low_ff  <= nxt_bit_time;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign oscillator_trim_value       = trim_ff;
  assign wake_receiver_select        = rx_sel_ff;
  assign filter_time_constant_select = filter_sel_t'(filt_ff);
  assign recovery_enable             = en_ff;
  assign recovery_clock_select       = rec_clk_sel_t'(clk_sel_ff);
  assign bit_time_length_value       = bit_time_ff;

endmodule // wake_frame_recovery_config

`default_nettype wire

// >>> verif/wake_recovery_cfg_sva.sv
`timescale 1ns/1ns
`default_nettype none
// Port-level checks for the wake frame recovery configuration block.
module wake_recovery_cfg_sva
  import wake_recovery_pkg::*;
(
  input wire logic                          clk_sys,
  input wire logic                          reset_n,
  input wire logic                          soft_reset,
  input wire logic                          spi_csn,
  input wire logic                          spi_miso_out,
  input wire logic                          spi_miso_oe_n,
  input wire logic [1:0]                    trim_unlock_key,
  input wire logic                          wake_rx_data,
  input wire logic [6:0]                    oscillator_trim_value,
  input wire logic                          wake_receiver_select,
  input wire wake_recovery_pkg::filter_sel_t  filter_time_constant_select,
  input wire logic                          recovery_enable,
  input wire wake_recovery_pkg::rec_clk_sel_t recovery_clock_select,
  input wire logic [7:0]                    bit_time_length_value
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);

  // ----------------------------------------------------------------
  // Sequences
  // ----------------------------------------------------------------
  // A host that stays deselected for three cycles.
  sequence deselect_seq;
    spi_csn [*3];
  endsequence
  // An edge on the received wake line within the last three samples.
  sequence rx_moved_seq;
    ($past(wake_rx_data, 1) != $past(wake_rx_data, 2)) || ($past(wake_rx_data, 2) != $past(wake_rx_data, 3));
  endsequence

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  // The data pin is only enabled while the host selects the device.
  oe_follows_select_a: assert property (spi_miso_oe_n == spi_csn)
    else $error("miso enable differs from chip select");
  // A deselected device keeps its data output low.
  miso_idle_low_a: assert property (deselect_seq |-> !spi_miso_out)
    else $error("miso not low while deselected");
  // The first edge after reset shows the reset configuration.
  reset_config_a: assert property (!$past(reset_n) |-> !wake_receiver_select && !recovery_enable
      && filter_time_constant_select == FILT_TC_16 && recovery_clock_select == REC_CLK_80)
    else $error("configuration wrong after reset");
  // A soft reset reloads the same configuration one edge later.
  soft_config_a: assert property (soft_reset |=> !wake_receiver_select && !recovery_enable
      && filter_time_constant_select == FILT_TC_16 && bit_time_length_value == 8'ha0)
    else $error("configuration wrong after soft reset");
  // The trim field only moves when the unlock key was presented.
  trim_key_gate_a: assert property ($changed(oscillator_trim_value) && !$past(soft_reset)
      |-> $past(trim_unlock_key, 1) == 2'h3 || $past(trim_unlock_key, 2) == 2'h3)
    else $error("trim changed without unlock key");
  // The receiver choice only moves when the unlock key was presented.
  rxsel_key_gate_a: assert property ($changed(wake_receiver_select) && !$past(soft_reset)
      |-> $past(trim_unlock_key, 1) == 2'h3 || $past(trim_unlock_key, 2) == 2'h3)
    else $error("receiver select changed without unlock key");
  // Recovery settings change only once a frame has closed.
  frame_commit_a: assert property (($changed(recovery_enable) || $changed(filter_time_constant_select)
      || $changed(recovery_clock_select)) && !$past(soft_reset) |-> spi_csn && $past(spi_csn))
    else $error("recovery setting changed inside a frame");
  // A disabled recovery holds its bit time.
  bit_time_hold_a: assert property (!recovery_enable && !$past(recovery_enable) && !soft_reset
      |=> $stable(bit_time_length_value))
    else $error("bit time moved while recovery disabled");
  // The bit time only moves just after a received edge.
  bit_time_edge_a: assert property ($changed(bit_time_length_value) && !$past(soft_reset) |-> rx_moved_seq)
    else $error("bit time moved without a received edge");
endmodule // wake_recovery_cfg_sva
`default_nettype wire

// >>> verif/host_spi_model.sv
`timescale 1ns/1ns
`default_nettype none
// Host side of the command link: sixteen bits per frame, address byte then data byte, LSB first.
module host_spi_model (
  input  wire logic       clk_sys,
  output logic            spi_csn,
  output logic            spi_sclk,
  output logic            spi_mosi,
  input  wire logic       spi_miso_out,
  output logic            rd_done,
  output logic [7:0]      rd_data
);
  // Deselected, serial clock parked low.
  initial begin
    spi_csn  = 1'b1;
    spi_sclk = 1'b0;
    spi_mosi = 1'b0;
    rd_done  = 1'b0;
    rd_data  = 8'h00;
  end

  // A released data line flips every cycle so a stale bit can never be mistaken for data.
  always @(posedge clk_sys) begin
    if (spi_csn) begin
      #1 spi_mosi = ~spi_mosi;
    end
  end

  // Waits whole cycles, then steps just past the edge.
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_sys);
    #2;
  endtask

  // Sends one frame; a read hands the returned byte over with a one-cycle strobe.
  task automatic xfer(input logic [6:0] addr, input logic wr, input logic [7:0] data, input int nbits = 16);
    logic [15:0] word;
    logic [7:0]  got;
    word = {data, wr, addr};
    got  = 8'h00;
    cyc(1);
    spi_csn = 1'b0;
    for (int i = 0; i < nbits; i++) begin
      spi_mosi = word[i];
      cyc(4);
      if (i >= 8) got[i-8] = spi_miso_out;
      spi_sclk = 1'b1;
      cyc(4);
      spi_sclk = 1'b0;
    end
    cyc(4);
    spi_csn = 1'b1;
    cyc(4);
    if (!wr) begin
      rd_data = got;
      rd_done = 1'b1;
      cyc(1);
      rd_done = 1'b0;
    end
    cyc(2);
  endtask
endmodule // host_spi_model
`default_nettype wire

// >>> verif/wake_frame_recovery_config_tb.sv
`timescale 1ns/1ns
`include "wake_recovery_defs.svh"
`default_nettype none
module wake_frame_recovery_config_tb;
  import wake_recovery_pkg::*;
  logic clk_sys, reset_n, soft_reset, osc_tick, wake_rx_data;
  logic spi_csn, spi_sclk, spi_mosi, spi_miso_out, spi_miso_oe_n, recovery_enable, wake_receiver_select;
  logic rd_done;
  logic [7:0] rd_data, bit_time_length_value, v;
  logic [1:0] trim_unlock_key, f;
  logic [6:0] oscillator_trim_value;
  logic [15:0] lfsr_ff = 16'd2793;
  filter_sel_t filter_time_constant_select;
  rec_clk_sel_t recovery_clock_select;
  logic [7:0] exp_q[$];
  int failures = 0, total_checks = 0;

  // Clock and a free-running oscillator tick every other cycle.
  always #20 clk_sys = ~clk_sys;
  always @(posedge clk_sys) #2 osc_tick = ~osc_tick;

  wake_frame_recovery_config uut (.clk_sys(clk_sys), .reset_n(reset_n), .soft_reset(soft_reset),
    .spi_csn(spi_csn), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi), .spi_miso_out(spi_miso_out),
    .spi_miso_oe_n(spi_miso_oe_n), .trim_unlock_key(trim_unlock_key), .osc_tick(osc_tick),
    .wake_rx_data(wake_rx_data), .oscillator_trim_value(oscillator_trim_value),
    .wake_receiver_select(wake_receiver_select), .filter_time_constant_select(filter_time_constant_select),
    .recovery_enable(recovery_enable), .recovery_clock_select(recovery_clock_select),
    .bit_time_length_value(bit_time_length_value));
  host_spi_model host (.clk_sys(clk_sys), .spi_csn(spi_csn), .spi_sclk(spi_sclk), .spi_mosi(spi_mosi),
    .spi_miso_out(spi_miso_out), .rd_done(rd_done), .rd_data(rd_data));

  // Pseudo-random byte source.
  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction

  task automatic check(input logic [7:0] seen, input logic [7:0] want);
    total_checks++;
    if (seen !== want) begin
      failures++;
      $display("FAIL at %0t: saw %h expected %h", $time, seen, want);
    end
  endtask

  task automatic complete_run();
    if (exp_q.size() != 0) failures++;
    $display("checks %0d mismatches %0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // Bus helpers: reads note their expected byte before the frame goes out.
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    host.xfer(a, 1'b1, d);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    exp_q.push_back(e);
    lfsr_ff = lfsr_next(lfsr_ff);
    host.xfer(a, 1'b0, lfsr_ff[7:0]);
  endtask
  // Toggles the wake line after each gap of whole cycles, then lets the bit time settle.
  task automatic toggle(input int n, input int gap);
    repeat (n) begin
      host.cyc(gap);
      wake_rx_data = ~wake_rx_data;
    end
    host.cyc(4);
  endtask

  // The full register image that reset and soft reset both establish.
  task automatic check_reset();
    rd(`ADDR_OSC_TRIM, {`TRIM_PRESET_BIT, `TRIM_VALUE_RST});
    rd(`ADDR_WAKE_OPTIONS, {`WAKE_RX_SEL_RST, 2'h0, `OPT_PRESET_BITS});
    rd(`ADDR_OSC_CAL_HIGH, 8'h00);
    rd(`ADDR_OSC_CAL_LOW, 8'h00);
    rd(`ADDR_REC_CTRL_ONE, 8'h04);
    rd(`ADDR_REC_CTRL_TWO, 8'h00);
    rd(`ADDR_REC_UPPER_LIM, 8'ha8);
    rd(`ADDR_REC_LOWER_LIM, 8'h98);
    check(wake_receiver_select, 8'h00);
    check(spi_miso_oe_n, 8'h01);
  endtask

  // Each returned byte is matched against the oldest note.
  always @(posedge clk_sys) begin
    if (rd_done === 1'b1) begin
      if (exp_q.size() == 0) check(rd_data, 8'hxx);
      else check(rd_data, exp_q.pop_front());
    end
  end

  // Guard against a hang.
  initial begin
    repeat (95000) @(posedge clk_sys);
    failures++;
    complete_run();
  end

  initial begin
    clk_sys = 1'b0;
    reset_n = 1'b0;
    soft_reset = 1'b0;
    osc_tick = 1'b0;
    wake_rx_data = 1'b1;
    trim_unlock_key = 2'h0;
    repeat (6) @(posedge clk_sys);
    #2 reset_n = 1'b1;
    check_reset();
    rd(7'h37, 8'h00);
    // Locked writes to trim, options and the read-only calibration bytes are ignored.
    trim_unlock_key = 2'h1;
    wr(`ADDR_OSC_TRIM, 8'h15);
    trim_unlock_key = 2'h2;
    wr(`ADDR_WAKE_OPTIONS, 8'h80);
    wr(`ADDR_OSC_CAL_HIGH, 8'hff);
    wr(`ADDR_OSC_CAL_LOW, 8'hff);
    rd(`ADDR_OSC_TRIM, 8'h40);
    rd(`ADDR_WAKE_OPTIONS, 8'h00);
    rd(`ADDR_OSC_CAL_HIGH, 8'h00);
    rd(`ADDR_OSC_CAL_LOW, 8'h00);
    // Unlocked writes keep the preset bits as they were.
    trim_unlock_key = 2'h3;
    wr(`ADDR_OSC_TRIM, {`TRIM_PRESET_BIT, 7'h15});
    wr(`ADDR_WAKE_OPTIONS, {1'b1, 2'h0, `OPT_PRESET_BITS});
    trim_unlock_key = 2'h0;
    rd(`ADDR_OSC_TRIM, 8'h15);
    rd(`ADDR_WAKE_OPTIONS, 8'h80);
    check(oscillator_trim_value, 8'h15);
    check(wake_receiver_select, 8'h01);
    // Every filter and clock code, with all reserved bits written as ones.
    for (int i = 0; i < 4; i++) begin
      f = 2'(i);
      wr(`ADDR_REC_CTRL_ONE, {4'hf, f, 2'h2});
      wr(`ADDR_REC_CTRL_TWO, {6'h3f, f});
      rd(`ADDR_REC_CTRL_ONE, {4'h0, f, 2'h0});
      rd(`ADDR_REC_CTRL_TWO, {6'h00, f});
      check(filter_time_constant_select, {6'h00, f});
      check(recovery_clock_select, {6'h00, f});
    end
    // Limit registers hold arbitrary bytes, then the recommended pair.
    repeat (3) begin
      lfsr_ff = lfsr_next(lfsr_ff);
      v = lfsr_ff[7:0];
      wr(`ADDR_REC_UPPER_LIM, v);
      wr(`ADDR_REC_LOWER_LIM, ~v);
      rd(`ADDR_REC_UPPER_LIM, v);
      rd(`ADDR_REC_LOWER_LIM, ~v);
    end
    // A frame cut short after twelve bits writes nothing.
    host.xfer(`ADDR_REC_UPPER_LIM, 1'b1, ~v, 12);
    rd(`ADDR_REC_UPPER_LIM, v);
    // Recovery at the fastest clock with a short filter; long gaps clamp high, short gaps clamp low.
    wr(`ADDR_REC_UPPER_LIM, 8'ha8);
    wr(`ADDR_REC_LOWER_LIM, 8'h98);
    wr(`ADDR_REC_CTRL_TWO, 8'h00);
    wr(`ADDR_REC_CTRL_ONE, 8'h01);
    check(recovery_enable, 8'h01);
    toggle(30, 600);
    check((bit_time_length_value > 8'ha0) && (bit_time_length_value <= 8'ha8), 8'h01);
    toggle(30, 20);
    check((bit_time_length_value >= 8'h98) && (bit_time_length_value < 8'ha0), 8'h01);
    // The slower pairing with the adaptive filter pulls the bit time into its own window.
    wr(`ADDR_REC_CTRL_TWO, 8'h01);
    wr(`ADDR_REC_LOWER_LIM, 8'h4c);
    wr(`ADDR_REC_UPPER_LIM, 8'h54);
    wr(`ADDR_REC_CTRL_ONE, 8'h0d);
    check(filter_time_constant_select, 8'h03);
    toggle(30, 600);
    check((bit_time_length_value >= 8'h4c) && (bit_time_length_value <= 8'h54), 8'h01);
    // Disabled recovery ignores edges; then a soft reset restores everything.
    wr(`ADDR_REC_CTRL_ONE, 8'h00);
    v = bit_time_length_value;
    toggle(4, 40);
    check(bit_time_length_value, v);
    soft_reset = 1'b1;
    host.cyc(1);
    soft_reset = 1'b0;
    check_reset();
    check(bit_time_length_value, `BIT_TIME_RST);
    host.cyc(4);
    complete_run();
  end
endmodule // wake_frame_recovery_config_tb

bind wake_frame_recovery_config wake_recovery_cfg_sva chk (.clk_sys(clk_sys), .reset_n(reset_n),
  .soft_reset(soft_reset), .spi_csn(spi_csn), .spi_miso_out(spi_miso_out), .spi_miso_oe_n(spi_miso_oe_n),
  .trim_unlock_key(trim_unlock_key), .wake_rx_data(wake_rx_data), .oscillator_trim_value(oscillator_trim_value),
  .wake_receiver_select(wake_receiver_select), .filter_time_constant_select(filter_time_constant_select),
  .recovery_enable(recovery_enable), .recovery_clock_select(recovery_clock_select),
  .bit_time_length_value(bit_time_length_value));
`default_nettype wire
